// file: core/cei_defines.svh
// Register offsets, field positions, limits and reset values of the error and interrupt block
`ifndef CEI_DEFINES_SVH
`define CEI_DEFINES_SVH

// Register offsets
`define CEI_TXCNT_ADDR 8'h1C
`define CEI_RXCNT_ADDR 8'h1D
`define CEI_INTE_ADDR 8'h2B
`define CEI_INTF_ADDR 8'h2C
`define CEI_ESTAT_ADDR 8'h2D
`define CEI_STAT_ADDR 8'h3E

// Enable and flag bit positions, shared order
`define CEI_BIT_RX0 0
`define CEI_BIT_RX1 1
`define CEI_BIT_TX0 2
`define CEI_BIT_TX1 3
`define CEI_BIT_TX2 4
`define CEI_BIT_ERR 5
`define CEI_BIT_WAK 6
`define CEI_BIT_MERR 7

// Error status flag positions
`define CEI_EF_ANYWARN 0
`define CEI_EF_RXWARN 1
`define CEI_EF_TXWARN 2
`define CEI_EF_RXPASS 3
`define CEI_EF_TXPASS 4
`define CEI_EF_BUSOFF 5
`define CEI_EF_OVR0 6
`define CEI_EF_OVR1 7

// Pending source code position in the status register
`define CEI_ICODE_LSB 1

// Counter limits and steps
`define CEI_WARN_LIMIT 8'h60
`define CEI_PASSIVE_LIMIT 8'h80
`define CEI_TXCNT_MAX 8'hFF
`define CEI_ERR_STEP 9'h008

// Bus-off recovery sequence
`define CEI_RECESSIVE_RUN 11
`define CEI_RUN_COUNT 128

// Reset values
`define CEI_RESET_BYTE 8'h00

`endif

// file: core/cei_pkg.sv
// Types shared by the error and interrupt block
package cei_pkg;

  typedef enum logic [1:0] {
    ERR_ACTIVE,
    ERR_PASSIVE,
    ERR_BUS_OFF
  } cei_state_t;

  typedef logic [7:0] cei_byte_t;

endpackage

// file: core/cei_recovery.sv
// Bus-off recovery sequence detector: counts runs of consecutive recessive bits
`timescale 1ns/10ps
`include "cei_defines.svh"

module cei_recovery #(
  parameter int unsigned RUN_LEN = `CEI_RECESSIVE_RUN,
  parameter int unsigned RUN_COUNT = `CEI_RUN_COUNT
) (
  input wire logic clk_in,       // System clock
  input wire logic rst_n_in,     // Asynchronous reset, active low
  input wire logic ce_in,        // Clock enable
  input wire logic active_in,    // Device is bus-off
  input wire logic bit_strobe_in, // One pulse per sampled bus bit
  input wire logic recessive_in, // Sampled bit is recessive
  output logic done_out          // Pulse when the sequence is complete
);

  logic [3:0] run_q;
  logic [7:0] occ_q;
  wire run_end = recessive_in && (run_q == 4'(RUN_LEN - 1));
  wire occ_end = run_end && (occ_q == 8'(RUN_COUNT - 1));

  // Runs count cumulatively; a dominant bit only restarts the current run
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      run_q <= 4'h0;
      occ_q <= 8'h00;
      done_out <= 1'b0;
    end else if (ce_in) begin
      done_out <= 1'b0;
      if (!active_in) begin
        run_q <= 4'h0;
        occ_q <= 8'h00;
      end else if (bit_strobe_in) begin
        run_q <= (!recessive_in || run_end) ? 4'h0 : run_q + 4'h1;
        occ_q <= occ_end ? 8'h00 : (run_end ? occ_q + 8'h01 : occ_q);
        done_out <= occ_end;
      end
    end
  end

endmodule

// file: core/cei_prio.sv
// Priority encoder giving the pending source code of enabled, pending interrupts
`timescale 1ns/10ps
`include "cei_defines.svh"

module cei_prio (
  input wire logic [7:0] pending_in, // Flags already gated by their enables
  output logic [2:0] code_out        // Code of the top pending source
);

  // Lower code wins; the message error source has no code of its own
  assign code_out =
    pending_in[`CEI_BIT_ERR] ? 3'h1 :
    pending_in[`CEI_BIT_WAK] ? 3'h2 :
    pending_in[`CEI_BIT_TX0] ? 3'h3 :
    pending_in[`CEI_BIT_TX1] ? 3'h4 :
    pending_in[`CEI_BIT_TX2] ? 3'h5 :
    pending_in[`CEI_BIT_RX0] ? 3'h6 :
    pending_in[`CEI_BIT_RX1] ? 3'h7 : 3'h0;

endmodule

// file: core/cei_top.sv
// Error confinement tracking, interrupt flags and register access of the CAN controller
`timescale 1ns/10ps
`include "cei_defines.svh"

// Overview of operation
// - Error-active while both counters stay below 128.
// - Error-passive while either counter is 128 or more and not bus-off.
// - Bus-off when the transmit counter runs past its top; held until recovery.
// - Leave bus-off alone after 128 runs of 11 recessive bits.
// - Combined warning set while either counter is 96 or more.
// - Transmit and receive warning flags follow their own counter against 96.
// - Transmit and receive passive flags follow their own counter against 128.
// - Bus-off flag set at count 255, cleared only by recovery.
// - Overflow flag set on a load into a full buffer; host clears it.
// - Both error counters are readable at their fixed addresses.
// - Eight sources, each with an enable bit and a flag bit.
// - Interrupt output low while any enabled flag is pending.
// - A host clear is refused while its setting condition persists.
// - Host may set flags; an enabled set flag raises the interrupt.
// - Report top pending enabled source other than message error as a 3-bit prioritised code.
// - Code counts only enabled sources and moves on once cleared.
// - Transmit buffer empty sets its flag.
// - Receive buffer loaded after end of frame sets its full flag.
// - Any message error sets the message error flag.
// - Bus activity in sleep with wakeup enabled sets wakeup, leaves to listen-only.
// - Overflow or error state change raises the error interrupt when enabled.
// - Enable and flag registers share one bit order.
module cei_top #(
  parameter int unsigned RUN_LEN = `CEI_RECESSIVE_RUN,
  parameter int unsigned RUN_COUNT = `CEI_RUN_COUNT
) (
  input wire logic SYS_CLK_IN,         // System clock, 200 MHz
  input wire logic RESET_N_IN,         // Asynchronous reset, active low
  input wire logic CLK_EN_IN,          // Clock enable, freezes all state when low
  input wire logic [7:0] REG_ADDR_IN,  // Register address
  input wire logic REG_WR_IN,          // Register write strobe
  input wire logic REG_RD_IN,          // Register read strobe
  input wire logic [7:0] REG_MASK_IN,  // Bit-modify mask, all ones for a plain write
  input wire logic [7:0] REG_WDATA_IN, // Write data
  input wire logic TX_ERR_IN,          // Transmit error, counter up by eight
  input wire logic TX_OK_IN,           // Transmit success, counter down by one
  input wire logic RX_ERR_IN,          // Receive error, counter up by one
  input wire logic RX_ERR8_IN,         // Severe receive error, counter up by eight
  input wire logic RX_OK_IN,           // Receive success, counter down by one
  input wire logic BIT_STROBE_IN,      // One pulse per sampled bus bit
  input wire logic BIT_RECESSIVE_IN,   // Sampled bit is recessive
  input wire logic [2:0] TX_EMPTY_IN,  // Transmit buffer became empty
  input wire logic [1:0] RX_LOADED_IN, // Accepted message completed for a receive buffer
  input wire logic MSG_ERROR_IN,       // Error while sending or receiving a message
  input wire logic SLEEP_IN,           // Device is sleeping
  input wire logic BUS_ACTIVITY_IN,    // Bus activity seen
  output logic [7:0] REG_RDATA_OUT,    // Read data
  output logic REG_RVALID_OUT,         // Read data valid pulse
  output logic INT_N_OUT,              // Interrupt, active low
  output logic [2:0] ICODE_OUT,        // Pending source code
  output logic ERR_PASSIVE_OUT,        // Device is error-passive
  output logic BUS_OFF_OUT,            // Device is bus-off
  output logic WAKE_LISTEN_OUT         // Pulse: leave sleep into listen-only
);

  cei_pkg::cei_state_t state_q;
  cei_pkg::cei_state_t state_d;
  cei_pkg::cei_byte_t txcnt_q;
  cei_pkg::cei_byte_t rxcnt_q;
  cei_pkg::cei_byte_t en_q;
  cei_pkg::cei_byte_t flag_q;
  cei_pkg::cei_byte_t flag_d;
  logic [5:0] status_q;
  logic [1:0] ovr_q;
  logic recov_done;
  logic [2:0] code_d;

  function automatic logic [7:0] merge_bits(input logic [7:0] old_val,
                                            input logic [7:0] mask,
                                            input logic [7:0] data);
    merge_bits = (old_val & ~mask) | (data & mask);
  endfunction

  // Register decode
  wire en_wr = REG_WR_IN && (REG_ADDR_IN == `CEI_INTE_ADDR);
  wire flag_wr = REG_WR_IN && (REG_ADDR_IN == `CEI_INTF_ADDR);
  wire estat_wr = REG_WR_IN && (REG_ADDR_IN == `CEI_ESTAT_ADDR);
  wire [7:0] en_d = en_wr ? merge_bits(en_q, REG_MASK_IN, REG_WDATA_IN) : en_q;
  wire [7:0] flag_merge = merge_bits(flag_q, REG_MASK_IN, REG_WDATA_IN);
  wire [7:0] estat_merge = merge_bits({ovr_q, status_q}, REG_MASK_IN, REG_WDATA_IN);

  // Transmit error counter; bus-off freezes it at the top
  wire in_bus_off = (state_q == cei_pkg::ERR_BUS_OFF);
  wire [8:0] txcnt_up = {1'b0, txcnt_q} + `CEI_ERR_STEP;
  wire txcnt_dec = TX_OK_IN && (txcnt_q != 8'h00);
  wire [8:0] txcnt_sum = TX_ERR_IN ? txcnt_up :
                         (txcnt_dec ? {1'b0, txcnt_q} - 9'h001 : {1'b0, txcnt_q});
  // Count saturates at 255, so reaching it stands for running past it
  wire busoff_hit = !in_bus_off && (txcnt_sum >= {1'b0, `CEI_TXCNT_MAX});
  wire [7:0] txcnt_d = recov_done ? 8'h00 :
                       (in_bus_off || busoff_hit) ? `CEI_TXCNT_MAX : txcnt_sum[7:0];

  // Receive error counter, saturating
  wire rxcnt_inc = RX_ERR_IN || RX_ERR8_IN;
  wire [8:0] rxcnt_up = {1'b0, rxcnt_q} + (RX_ERR8_IN ? `CEI_ERR_STEP : 9'h001);
  wire [7:0] rxcnt_sat = rxcnt_up[8] ? 8'hFF : rxcnt_up[7:0];
  wire rxcnt_dec = RX_OK_IN && (rxcnt_q != 8'h00);
  wire [7:0] rxcnt_d = recov_done ? 8'h00 :
                       in_bus_off ? rxcnt_q :
                       rxcnt_inc ? rxcnt_sat :
                       rxcnt_dec ? rxcnt_q - 8'h01 : rxcnt_q;

  wire pass_d = (txcnt_d >= `CEI_PASSIVE_LIMIT) || (rxcnt_d >= `CEI_PASSIVE_LIMIT);

  always_comb begin
    state_d = state_q;
    case (state_q)
      cei_pkg::ERR_ACTIVE, cei_pkg::ERR_PASSIVE: begin
        if (busoff_hit) begin
          state_d = cei_pkg::ERR_BUS_OFF;
        end else if (pass_d) begin
          state_d = cei_pkg::ERR_PASSIVE;
        end else begin
          state_d = cei_pkg::ERR_ACTIVE;
        end
      end
      cei_pkg::ERR_BUS_OFF: begin
        if (recov_done) begin
          state_d = cei_pkg::ERR_ACTIVE;
        end
      end
      default: state_d = cei_pkg::ERR_ACTIVE;
    endcase
  end

  cei_recovery #(
    .RUN_LEN(RUN_LEN),
    .RUN_COUNT(RUN_COUNT)
  ) u_recovery (
    .clk_in(SYS_CLK_IN),
    .rst_n_in(RESET_N_IN),
    .ce_in(CLK_EN_IN),
    .active_in(in_bus_off),
    .bit_strobe_in(BIT_STROBE_IN),
    .recessive_in(BIT_RECESSIVE_IN),
    .done_out(recov_done)
  );

  // Error status flags derived from the next counter values
  wire tx_war_d = (txcnt_d >= `CEI_WARN_LIMIT);
  wire rx_war_d = (rxcnt_d >= `CEI_WARN_LIMIT);
  wire [5:0] status_d = {
    (state_d == cei_pkg::ERR_BUS_OFF),
    (txcnt_d >= `CEI_PASSIVE_LIMIT),
    (rxcnt_d >= `CEI_PASSIVE_LIMIT),
    tx_war_d,
    rx_war_d,
    tx_war_d || rx_war_d
  };

  // Overflow: hardware sets, host may only clear, set wins
  wire [1:0] full_q = {flag_q[`CEI_BIT_RX1], flag_q[`CEI_BIT_RX0]};
  wire [1:0] ovr_set = RX_LOADED_IN & full_q;
  wire [1:0] ovr_keep = estat_wr ? estat_merge[`CEI_EF_OVR1:`CEI_EF_OVR0] : 2'b11;
  wire [1:0] ovr_d = ovr_set | (ovr_q & ovr_keep);

  // Interrupt sources
  wire wake_evt = SLEEP_IN && BUS_ACTIVITY_IN && en_q[`CEI_BIT_WAK];
  wire err_evt = en_q[`CEI_BIT_ERR] && ((status_d != status_q) || (|ovr_set));
  wire [7:0] set_evt = {
    MSG_ERROR_IN,
    wake_evt,
    err_evt,
    TX_EMPTY_IN,
    RX_LOADED_IN
  };
  // A pending overflow is the persisting cause of the error flag
  wire [7:0] hold = set_evt | ({7'h00, |ovr_q} << `CEI_BIT_ERR);

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      // Host writes may set, clear only where no cause persists; set wins
      assign flag_d[gi] = set_evt[gi] |
        (flag_wr ? (flag_merge[gi] | (flag_q[gi] & hold[gi])) : flag_q[gi]);
    end
  endgenerate

  wire [7:0] pend_d = flag_d & en_d;

  cei_prio u_prio (
    .pending_in(pend_d),
    .code_out(code_d)
  );

  // Read multiplexer; unmapped addresses read zero
  wire [7:0] stat_rd = {4'h0, ICODE_OUT, 1'b0} & 8'h0E;
  wire [7:0] rd_mux =
    (REG_ADDR_IN == `CEI_TXCNT_ADDR) ? txcnt_q :
    (REG_ADDR_IN == `CEI_RXCNT_ADDR) ? rxcnt_q :
    (REG_ADDR_IN == `CEI_INTE_ADDR) ? en_q :
    (REG_ADDR_IN == `CEI_INTF_ADDR) ? flag_q :
    (REG_ADDR_IN == `CEI_ESTAT_ADDR) ? {ovr_q, status_q} :
    (REG_ADDR_IN == `CEI_STAT_ADDR) ? stat_rd : `CEI_RESET_BYTE;

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      state_q <= cei_pkg::ERR_ACTIVE;
      txcnt_q <= `CEI_RESET_BYTE;
      rxcnt_q <= `CEI_RESET_BYTE;
      status_q <= 6'h00;
      ovr_q <= 2'b00;
    end else if (CLK_EN_IN) begin
      state_q <= state_d;
      txcnt_q <= txcnt_d;
      rxcnt_q <= rxcnt_d;
      status_q <= status_d;
      ovr_q <= ovr_d;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      en_q <= `CEI_RESET_BYTE;
      flag_q <= `CEI_RESET_BYTE;
      INT_N_OUT <= 1'b1;
      ICODE_OUT <= 3'h0;
    end else if (CLK_EN_IN) begin
      en_q <= en_d;
      flag_q <= flag_d;
      INT_N_OUT <= ~(|pend_d);
      ICODE_OUT <= code_d;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      REG_RDATA_OUT <= `CEI_RESET_BYTE;
      REG_RVALID_OUT <= 1'b0;
      ERR_PASSIVE_OUT <= 1'b0;
      BUS_OFF_OUT <= 1'b0;
      WAKE_LISTEN_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      REG_RVALID_OUT <= REG_RD_IN;
      if (REG_RD_IN) begin
        REG_RDATA_OUT <= rd_mux;
      end
      ERR_PASSIVE_OUT <= (state_d == cei_pkg::ERR_PASSIVE);
      BUS_OFF_OUT <= (state_d == cei_pkg::ERR_BUS_OFF);
      WAKE_LISTEN_OUT <= wake_evt;
    end
  end

  // Checks
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RESET_N_IN);

  a_state_active: assert property (
    (txcnt_q < 8'h80 && rxcnt_q < 8'h80) |-> (state_q == cei_pkg::ERR_ACTIVE) || BUS_OFF_OUT)
    else $error("counters low but not error-active");

  a_state_passive: assert property (
    (state_q != cei_pkg::ERR_BUS_OFF && (txcnt_q >= 8'h80 || rxcnt_q >= 8'h80))
      |-> ERR_PASSIVE_OUT && !status_q[`CEI_EF_BUSOFF])
    else $error("counter at passive limit but not error-passive");

  a_busoff_enter: assert property (
    (CLK_EN_IN && TX_ERR_IN && txcnt_q >= 8'hF8 && state_q != cei_pkg::ERR_BUS_OFF)
      |=> BUS_OFF_OUT && txcnt_q == 8'hFF && status_q[`CEI_EF_BUSOFF])
    else $error("bus-off not entered on transmit counter overrun");

  a_busoff_holds: assert property (
    (BUS_OFF_OUT && !recov_done) |=> BUS_OFF_OUT || !CLK_EN_IN)
    else $error("bus-off left without recovery");

  a_recover_active: assert property (
    (CLK_EN_IN && recov_done && in_bus_off) |=> state_q == cei_pkg::ERR_ACTIVE
      && txcnt_q == 8'h00 && rxcnt_q == 8'h00 && !status_q[`CEI_EF_BUSOFF])
    else $error("recovery did not return to error-active with cleared counters");

  a_warn_flags: assert property (
    status_q[`CEI_EF_ANYWARN] == (txcnt_q >= 8'h60 || rxcnt_q >= 8'h60))
    else $error("combined warning does not follow counters");

  a_side_flags: assert property (
    status_q[`CEI_EF_TXPASS] == (txcnt_q >= 8'h80)
      && status_q[`CEI_EF_RXWARN] == (rxcnt_q >= 8'h60))
    else $error("passive or warning flag does not follow its counter");

  a_overflow_set: assert property (
    (CLK_EN_IN && RX_LOADED_IN[0] && flag_q[`CEI_BIT_RX0])
      |=> ovr_q[0] ##1 (ovr_q[0] || $past(estat_wr)))
    else $error("overflow not set or lost without host clear");

  a_int_level: assert property (
    INT_N_OUT == !(|(flag_q & en_q)))
    else $error("interrupt output does not match pending enabled flags");

  a_clear_refused: assert property (
    (CLK_EN_IN && flag_wr && |ovr_q && flag_q[`CEI_BIT_ERR]) |=> flag_q[`CEI_BIT_ERR])
    else $error("error flag cleared while overflow persists");

  a_host_set: assert property (
    (CLK_EN_IN && flag_wr && REG_MASK_IN[2] && REG_WDATA_IN[2] && en_q[2] && !en_wr)
      |=> flag_q[2] && !INT_N_OUT)
    else $error("host-set enabled flag did not raise interrupt");

  a_code_top: assert property (
    (flag_q[`CEI_BIT_ERR] && en_q[`CEI_BIT_ERR]) |-> ICODE_OUT == 3'h1)
    else $error("error source not reported first");

  a_code_none: assert property (
    !(|(flag_q & en_q & 8'h7F)) |-> ICODE_OUT == 3'h0)
    else $error("code reported with nothing enabled pending");

  a_msg_error: assert property (
    (CLK_EN_IN && MSG_ERROR_IN) |=> flag_q[`CEI_BIT_MERR])
    else $error("message error flag lost");

  a_wake: assert property (
    (CLK_EN_IN && SLEEP_IN && BUS_ACTIVITY_IN && en_q[`CEI_BIT_WAK])
      |=> flag_q[`CEI_BIT_WAK] && WAKE_LISTEN_OUT)
    else $error("wakeup not flagged in sleep");

  c_bus_off: cover property (!BUS_OFF_OUT ##1 BUS_OFF_OUT);
  c_recovery: cover property (BUS_OFF_OUT ##1 !BUS_OFF_OUT);
  c_overflow: cover property (!ovr_q[1] ##1 ovr_q[1]);
  c_wake: cover property (WAKE_LISTEN_OUT);

endmodule

// file: sim/cei_host.sv
// Host model driving the register port of the error and interrupt block
`timescale 1ns/10ps

module cei_host (
  input wire logic clk_in,         // System clock
  input wire logic rvalid_in,      // Read data valid
  input wire logic [7:0] rdata_in, // Read data
  output logic [7:0] addr_out,     // Register address
  output logic wr_out,             // Write strobe
  output logic rd_out,             // Read strobe
  output logic [7:0] mask_out,     // Bit-modify mask
  output logic [7:0] wdata_out     // Write data
);
  initial begin
    addr_out = 8'h00;
    wr_out = 1'h0;
    rd_out = 1'h0;
    mask_out = 8'h00;
    wdata_out = 8'h00;
  end

  // Flags are cleared through the mask so a flag set meanwhile survives
  task automatic reg_write(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    mask_out = m;
    wdata_out = d;
    wr_out = 1'h1;
    @(negedge clk_in);
    wr_out = 1'h0;
    // Released lines must not keep the last value
    wdata_out = ~d;
    mask_out = ~m;
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(negedge clk_in);
    addr_out = a;
    rd_out = 1'h1;
    @(negedge clk_in);
    rd_out = 1'h0;
    addr_out = ~a;
    while (rvalid_in !== 1'h1 && n < 4) begin
      @(negedge clk_in);
      n++;
    end
    d = (rvalid_in === 1'h1) ? rdata_in : 8'hXX;
  endtask
endmodule

// file: sim/tb.sv
// Self-checking testbench of the error and interrupt block
`timescale 1ns/10ps
`include "cei_defines.svh"

module tb;
  localparam int unsigned RUN_LEN = 3;
  localparam int unsigned RUN_COUNT = 2;
  localparam logic [11:0] TXE = 12'h001;
  localparam logic [11:0] TXOK = 12'h002;
  localparam logic [11:0] RXE = 12'h004;
  localparam logic [11:0] RXE8 = 12'h008;
  localparam logic [11:0] RXOK = 12'h010;
  localparam logic [11:0] ACT = 12'h020;
  localparam logic [11:0] RXL0 = 12'h400;
  logic sys_clk, reset_n, clk_en, strobe, recessive, sleep;
  logic wr, rd, rvalid, int_n, err_passive, bus_off, wake_listen;
  logic [11:0] evt;
  logic [7:0] addr, mask, wdata, rdata, rd_val;
  logic [2:0] icode;
  int miscompares, n_compared;
  int ord[7] = '{5, 2, 3, 4, 0, 1, 7};
  logic [2:0] code[7] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h0};

  cei_top #(.RUN_LEN(RUN_LEN), .RUN_COUNT(RUN_COUNT)) i_cei_top (
    .SYS_CLK_IN(sys_clk), .RESET_N_IN(reset_n), .CLK_EN_IN(clk_en),
    .REG_ADDR_IN(addr), .REG_WR_IN(wr), .REG_RD_IN(rd), .REG_MASK_IN(mask),
    .REG_WDATA_IN(wdata), .TX_ERR_IN(evt[0]), .TX_OK_IN(evt[1]), .RX_ERR_IN(evt[2]),
    .RX_ERR8_IN(evt[3]), .RX_OK_IN(evt[4]), .BIT_STROBE_IN(strobe),
    .BIT_RECESSIVE_IN(recessive), .TX_EMPTY_IN(evt[9:7]), .RX_LOADED_IN(evt[11:10]),
    .MSG_ERROR_IN(evt[6]), .SLEEP_IN(sleep), .BUS_ACTIVITY_IN(evt[5]),
    .REG_RDATA_OUT(rdata), .REG_RVALID_OUT(rvalid), .INT_N_OUT(int_n),
    .ICODE_OUT(icode), .ERR_PASSIVE_OUT(err_passive), .BUS_OFF_OUT(bus_off),
    .WAKE_LISTEN_OUT(wake_listen));

  cei_host i_cei_host (.clk_in(sys_clk), .rvalid_in(rvalid), .rdata_in(rdata),
    .addr_out(addr), .wr_out(wr), .rd_out(rd), .mask_out(mask), .wdata_out(wdata));

  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    i_cei_host.reg_read(a, rd_val);
    chk($sformatf("register %h", a), exp, rd_val);
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] m, input logic [7:0] d);
    i_cei_host.reg_write(a, m, d);
  endtask

  // One event per cycle for n cycles; outputs settled on return
  task automatic ev(input logic [11:0] v, input int n);
    repeat (n) begin
      @(negedge sys_clk);
      evt = v;
    end
    @(negedge sys_clk);
    evt = 12'h000;
  endtask

  task automatic bits(input int n, input logic r);
    repeat (n) begin
      @(negedge sys_clk);
      strobe = 1'h1;
      recessive = r;
    end
    @(negedge sys_clk);
    strobe = 1'h0;
    recessive = ~r;
  endtask

  task automatic pins(input logic [2:0] ic, input logic in_n);
    chk("icode", {5'h00, ic}, {5'h00, icode});
    chk("int_n", {7'h00, in_n}, {7'h00, int_n});
  endtask

  initial begin
    sys_clk = 1'h0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end

  initial begin
    reset_n = 1'h0;
    clk_en = 1'h1;
    strobe = 1'h0;
    recessive = 1'h1;
    sleep = 1'h0;
    evt = 12'h000;
    miscompares = 0;
    n_compared = 0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'h1;
    pins(3'h0, 1'h1);
    foreach (ord[i]) rchk(8'h1C + 8'(i), 8'h00);
    rchk(`CEI_INTF_ADDR, 8'h00);
    rchk(`CEI_ESTAT_ADDR, 8'h00);
    rchk(`CEI_STAT_ADDR, 8'h00);
    // Counter thresholds, error interrupt on warning change
    wr_reg(`CEI_INTE_ADDR, 8'hFF, 8'h20);
    ev(TXE, 11);
    rchk(`CEI_TXCNT_ADDR, 8'h58);
    rchk(`CEI_ESTAT_ADDR, 8'h00);
    ev(TXE, 1);
    rchk(`CEI_ESTAT_ADDR, 8'h05);
    pins(3'h1, 1'h0);
    ev(TXOK, 1);
    rchk(`CEI_ESTAT_ADDR, 8'h00);
    ev(RXE8, 12);
    rchk(`CEI_RXCNT_ADDR, 8'h60);
    rchk(`CEI_ESTAT_ADDR, 8'h03);
    ev(RXOK, 1);
    rchk(`CEI_ESTAT_ADDR, 8'h00);
    ev(RXE, 1);
    ev(RXE8, 4);
    rchk(`CEI_ESTAT_ADDR, 8'h0B);
    chk("passive", 8'h01, {7'h00, err_passive});
    ev(RXOK, 1);
    chk("passive", 8'h00, {7'h00, err_passive});
    ev(TXE, 5);
    rchk(`CEI_ESTAT_ADDR, 8'h17);
    ev(TXE, 14);
    chk("bus_off", 8'h00, {7'h00, bus_off});
    ev(TXE, 1);
    chk("bus_off", 8'h01, {7'h00, bus_off});
    chk("passive", 8'h00, {7'h00, err_passive});
    rchk(`CEI_TXCNT_ADDR, 8'hFF);
    rchk(`CEI_ESTAT_ADDR, 8'h37);
    ev(RXOK, 1);
    rchk(`CEI_RXCNT_ADDR, 8'h7F);
    // Dominant bit restarts a run; a frozen clock enable holds all state
    bits(RUN_LEN - 1, 1'h1);
    bits(1, 1'h0);
    bits(RUN_LEN, 1'h1);
    @(negedge sys_clk);
    clk_en = 1'h0;
    bits(RUN_LEN, 1'h1);
    clk_en = 1'h1;
    chk("bus_off", 8'h01, {7'h00, bus_off});
    bits(RUN_LEN, 1'h1);
    @(negedge sys_clk);
    chk("bus_off", 8'h00, {7'h00, bus_off});
    rchk(`CEI_TXCNT_ADDR, 8'h00);
    rchk(`CEI_ESTAT_ADDR, 8'h00);
    wr_reg(`CEI_INTF_ADDR, 8'h20, 8'h00);
    pins(3'h0, 1'h1);
    // Disabled sources stay silent, then priority walk
    wr_reg(`CEI_INTE_ADDR, 8'hFF, 8'h00);
    ev(12'hFC0, 1);
    wr_reg(`CEI_INTF_ADDR, 8'h20, 8'h20);
    pins(3'h0, 1'h1);
    rchk(`CEI_INTF_ADDR, 8'hBF);
    wr_reg(`CEI_INTE_ADDR, 8'hFF, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      pins(code[i], 1'h0);
      wr_reg(`CEI_INTF_ADDR, 8'h01 << ord[i], 8'h00);
    end
    pins(3'h0, 1'h1);
    rchk(`CEI_STAT_ADDR, 8'h00);
    // Overflow, refused clears
    wr_reg(`CEI_INTE_ADDR, 8'hFF, 8'h21);
    ev(RXL0, 1);
    pins(3'h6, 1'h0);
    ev(RXL0, 1);
    rchk(`CEI_ESTAT_ADDR, 8'h40);
    wr_reg(`CEI_INTF_ADDR, 8'h20, 8'h00);
    rchk(`CEI_INTF_ADDR, 8'h21);
    wr_reg(`CEI_ESTAT_ADDR, 8'h40, 8'h00);
    rchk(`CEI_ESTAT_ADDR, 8'h00);
    fork
      wr_reg(`CEI_INTF_ADDR, 8'h21, 8'h00);
      ev(RXL0, 1);
    join
    rchk(`CEI_INTF_ADDR, 8'h21);
    wr_reg(`CEI_ESTAT_ADDR, 8'hC0, 8'h00);
    wr_reg(`CEI_INTF_ADDR, 8'hFF, 8'h00);
    pins(3'h0, 1'h1);
    // Wakeup only while sleeping
    wr_reg(`CEI_INTE_ADDR, 8'hFF, 8'h40);
    ev(ACT, 1);
    rchk(`CEI_INTF_ADDR, 8'h00);
    sleep = 1'h1;
    ev(ACT, 1);
    chk("wake", 8'h01, {7'h00, wake_listen});
    pins(3'h2, 1'h0);
    sleep = 1'h0;
    wr_reg(`CEI_INTF_ADDR, 8'h40, 8'h00);
    pins(3'h0, 1'h1);
    print_verdict();
  end
endmodule
